// ### core/lcr_regs.sv
// Register bank and channel control for the base layer and overlay-1 layer DMA channels.
// Assumes a plain register port synchronous to CLK and a DMA engine that reports events as pulses.
//
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none

module lcr_regs
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Register port
    input wire logic [31:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    // Base layer configuration to pixel path
    input wire logic BASE_ROW_DONE,
    input wire logic [31:0] BASE_ROW_ADDR_START,
    output logic [31:0] BASE_ROW_ADDR,
    output logic BASE_DMA_ON,
    output logic BASE_PAL_MODE,
    output logic [3:0] BASE_PAL_BPP,
    input wire logic [7:0] PIX_RED,
    input wire logic [7:0] PIX_GREEN,
    input wire logic [7:0] PIX_BLUE,
    input wire logic [3:0] PIX_COMP_BITS,
    output logic [23:0] BASE_PIXEL,
    // Overlay-1 channel control to DMA engine
    input wire logic OVL_SOF,
    input wire logic OVL_EOF,
    input wire logic OVL_HEAD_ADDED,
    output logic OVL_CHANNEL_ON,
    output logic OVL_ABORT,
    output logic OVL_APPLY_ATTR,
    output logic OVL_QUEUE_HEAD,
    // Overlay-1 events
    input wire logic EV_EOT,
    input wire logic EV_DESCRIPTOR_LOADED,
    input wire logic EV_HEAD,
    input wire logic EV_EOL,
    input wire logic EV_OVF,
    output logic OVL_IRQ
);

    localparam int N = lcr_pkg::IRQ_N;
    // Local widths and fill values, so the logic below holds no bare figures
    localparam int DEPTH_W = 2;
    localparam int PIX_W = 3 * lcr_pkg::COMP_W;
    localparam logic [3:0] BPP_NONE = 4'h0;
    localparam logic [3:0] COMP_FULL = 4'h8;
    localparam logic [3:0] COMP_NONE = 4'h0;
    localparam logic [23:0] PIX_ZERO = 24'h000000;
    localparam logic [31:0] WORD_ZERO = 32'h00000000;

    // Every output comes from a register or a plain decode of registers, so
    // the DMA engine sees no combinational path from the register port.
    // OVL_APPLY_ATTR is the exception: it is gated by the frame-start strobe
    // so that the engine can take the new attributes in that same cycle.

    logic pal_on_r;
    logic [1:0] pal_depth_r;
    logic [31:0] stride_r;
    logic [23:0] colour_r;
    logic dma_path_r;
    logic rep_r;
    logic [31:0] row_addr_r;
    logic ch_on_r;
    logic graceful_r;
    logic upd_r;
    logic qh_r;
    logic abort_r;
    logic [N-1:0] mask_r;
    logic [N-1:0] flags_r;
    logic [N-1:0] flags_nxt;
    logic [31:0] rdata_r;

    // Address decode; only full-address matches count, so aliases are unmapped
    wire wr_cfg1 = WR && (ADDR == lcr_pkg::OFF_BASE_CFG1);
    wire wr_stride = WR && (ADDR == lcr_pkg::OFF_ROW_STRIDE);
    wire wr_colour = WR && (ADDR == lcr_pkg::OFF_DEF_COLOUR);
    wire wr_path = WR && (ADDR == lcr_pkg::OFF_PATH_SEL);
    wire wr_channel_on = WR && (ADDR == lcr_pkg::OFF_CH_ENABLE);
    wire wr_graceful_off = WR && (ADDR == lcr_pkg::OFF_CH_DISABLE);
    wire wr_ien = WR && (ADDR == lcr_pkg::OFF_IRQ_ENABLE);
    wire wr_idis = WR && (ADDR == lcr_pkg::OFF_IRQ_DISABLE);
    wire rd_flags = RD && (ADDR == lcr_pkg::OFF_IRQ_FLAGS);

    wire set_on = wr_channel_on && WDATA[lcr_pkg::POS_CH_ON];
    wire set_upd = wr_channel_on && WDATA[lcr_pkg::POS_UPDATE];
    wire set_qh = wr_channel_on && WDATA[lcr_pkg::POS_QHEAD];
    wire set_grace = wr_graceful_off && WDATA[lcr_pkg::POS_GRACEFUL];
    wire do_abort = wr_graceful_off && WDATA[lcr_pkg::POS_ABORT];
    wire [N-1:0] ien_bits = WDATA[lcr_pkg::IRQ_LSB +: N];
    // Event vector in flag-bit order, lowest source first
    wire [N-1:0] events;
    assign events[lcr_pkg::SRC_EOT] = EV_EOT;
    assign events[lcr_pkg::SRC_DESCRIPTOR_LOADED] = EV_DESCRIPTOR_LOADED;
    assign events[lcr_pkg::SRC_HEAD] = EV_HEAD;
    assign events[lcr_pkg::SRC_EOL] = EV_EOL;
    assign events[lcr_pkg::SRC_OVF] = EV_OVF;
    wire end_grace = graceful_r && OVL_EOF;

    // Palette depth decode, only meaningful in palette mode
    logic [3:0] bpp;
    always_comb
    begin
        unique case (pal_depth_r)
            lcr_pkg::PAL_1BPP: bpp = lcr_pkg::BPP_1;
            lcr_pkg::PAL_2BPP: bpp = lcr_pkg::BPP_2;
            lcr_pkg::PAL_4BPP: bpp = lcr_pkg::BPP_4;
            lcr_pkg::PAL_8BPP: bpp = lcr_pkg::BPP_8;
        endcase
    end
    assign BASE_PAL_MODE = pal_on_r;
    assign BASE_PAL_BPP = pal_on_r ? bpp : BPP_NONE;

    // Component expansion: input holds the component right-aligned in PIX_COMP_BITS bits
    function automatic logic [7:0] expand(input logic [7:0] c, input logic [3:0] w,
                                          input logic msb_replicate);
        logic [7:0] sh;
        logic [3:0] pad;
        // Widths outside one to eight are not meaningful; replication is skipped
        pad = COMP_FULL - w;
        sh = c << pad;
        if (msb_replicate && (w != COMP_NONE) && (w < COMP_FULL))
            sh[0] = sh[lcr_pkg::COMP_W - 1];
        return sh;
    endfunction

    // Expanded stream components and default components
    wire [7:0] dma_red = expand(PIX_RED, PIX_COMP_BITS, rep_r);
    wire [7:0] dma_green = expand(PIX_GREEN, PIX_COMP_BITS, rep_r);
    wire [7:0] dma_blue = expand(PIX_BLUE, PIX_COMP_BITS, rep_r);
    wire [7:0] default_red = colour_r[lcr_pkg::POS_RED +: lcr_pkg::COMP_W];
    wire [7:0] default_green = colour_r[lcr_pkg::POS_GREEN +: lcr_pkg::COMP_W];
    wire [7:0] default_blue = colour_r[lcr_pkg::POS_BLUE +: lcr_pkg::COMP_W];
    wire [23:0] dma_pix = {dma_red, dma_green, dma_blue};
    wire [23:0] def_pix = {default_red, default_green, default_blue};
    assign BASE_DMA_ON = dma_path_r;

    // Base configuration registers, one short block per register
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            pal_on_r <= 1'b0;
            pal_depth_r <= 2'h0;
        end
        else if (wr_cfg1)
        begin
            pal_on_r <= WDATA[lcr_pkg::POS_PAL_ON];
            pal_depth_r <= WDATA[lcr_pkg::POS_PAL_DEPTH +: DEPTH_W];
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
            stride_r <= lcr_pkg::RESET_WORD;
        else if (wr_stride)
            stride_r <= WDATA;
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
            colour_r <= PIX_ZERO;
        else if (wr_colour)
            colour_r <= WDATA[PIX_W-1:0];
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            dma_path_r <= 1'b0;
            rep_r <= 1'b0;
        end
        else if (wr_path)
        begin
            dma_path_r <= WDATA[lcr_pkg::POS_DMA_PATH];
            rep_r <= WDATA[lcr_pkg::POS_REPLICATE];
        end
    end

    // Row address walker; steps on BASE_ROW_DONE, else reloads the frame base while the DMA path is off.
    // The sum wraps at the top of the address space, as the engine expects.
    always_ff @(posedge CLK)
    begin
        if (RST)
            row_addr_r <= lcr_pkg::RESET_WORD;
        else if (BASE_ROW_DONE)
            row_addr_r <= row_addr_r + stride_r;
        else if (!dma_path_r)
            row_addr_r <= BASE_ROW_ADDR_START;
    end
    assign BASE_ROW_ADDR = row_addr_r;

    // Output pixel, registered so downstream sees a settled word each cycle
    always_ff @(posedge CLK)
    begin
        if (RST)
            BASE_PIXEL <= PIX_ZERO;
        else
            BASE_PIXEL <= dma_path_r ? dma_pix : def_pix;
    end

    // Overlay-1 channel state; abort beats every pending request
    always_ff @(posedge CLK)
    begin
        if (RST)
            abort_r <= 1'b0;
        else
            abort_r <= do_abort;
    end

    always_ff @(posedge CLK)
    begin
        if (RST || do_abort)
            ch_on_r <= 1'b0;
        else if (set_on)
            ch_on_r <= 1'b1;
        else if (end_grace)
            ch_on_r <= 1'b0;
    end

    // A frame end drops the graceful request unless a new one is written in that cycle, so a stale one cannot fire later
    always_ff @(posedge CLK)
    begin
        if (RST || do_abort)
            graceful_r <= 1'b0;
        else if (set_grace)
            graceful_r <= 1'b1;
        else if (OVL_EOF)
            graceful_r <= 1'b0;
    end

    // A new request in the cycle the old one completes stays pending
    always_ff @(posedge CLK)
    begin
        if (RST || do_abort)
            upd_r <= 1'b0;
        else if (set_upd)
            upd_r <= 1'b1;
        else if (OVL_SOF)
            upd_r <= 1'b0;
    end

    always_ff @(posedge CLK)
    begin
        if (RST || do_abort)
            qh_r <= 1'b0;
        else if (set_qh)
            qh_r <= 1'b1;
        else if (OVL_HEAD_ADDED)
            qh_r <= 1'b0;
    end
    assign OVL_CHANNEL_ON = ch_on_r;
    assign OVL_ABORT = abort_r;
    assign OVL_APPLY_ATTR = upd_r && OVL_SOF;
    assign OVL_QUEUE_HEAD = qh_r;

    // Interrupt mask and clear-on-read flags, per source
    genvar gi;
    generate
        for (gi = 0; gi < N; gi++)
        begin : g_src
            // Set beats the read clear so no event is lost
            assign flags_nxt[gi] = events[gi] | (flags_r[gi] & ~rd_flags);
            always_ff @(posedge CLK)
            begin
                if (RST)
                    flags_r[gi] <= 1'b0;
                else
                    flags_r[gi] <= flags_nxt[gi];
            end
            always_ff @(posedge CLK)
            begin
                if (RST)
                    mask_r[gi] <= 1'b0;
                else if (wr_ien && ien_bits[gi])
                    mask_r[gi] <= 1'b1;
                else if (wr_idis && ien_bits[gi])
                    mask_r[gi] <= 1'b0;
            end
        end
    endgenerate
    assign OVL_IRQ = |(flags_r & mask_r);

    // Read selects; write-only and unmapped addresses match none and read zero
    wire rsel_cfg1 = (ADDR == lcr_pkg::OFF_BASE_CFG1);
    wire rsel_stride = (ADDR == lcr_pkg::OFF_ROW_STRIDE);
    wire rsel_colour = (ADDR == lcr_pkg::OFF_DEF_COLOUR);
    wire rsel_path = (ADDR == lcr_pkg::OFF_PATH_SEL);
    wire rsel_state = (ADDR == lcr_pkg::OFF_CH_STATE);
    wire rsel_mask = (ADDR == lcr_pkg::OFF_IRQ_MASK);
    wire rsel_flags = (ADDR == lcr_pkg::OFF_IRQ_FLAGS);

    // Readback words with unused bits at zero
    logic [31:0] cfg1_word;
    logic [31:0] colour_word;
    logic [31:0] path_word;
    logic [31:0] state_word;
    logic [31:0] mask_word;
    logic [31:0] flags_word;
    always_comb
    begin
        cfg1_word = WORD_ZERO;
        cfg1_word[lcr_pkg::POS_PAL_ON] = pal_on_r;
        cfg1_word[lcr_pkg::POS_PAL_DEPTH +: DEPTH_W] = pal_depth_r;
        colour_word = WORD_ZERO;
        colour_word[PIX_W-1:0] = colour_r;
        path_word = WORD_ZERO;
        path_word[lcr_pkg::POS_DMA_PATH] = dma_path_r;
        path_word[lcr_pkg::POS_REPLICATE] = rep_r;
        state_word = WORD_ZERO;
        state_word[lcr_pkg::POS_CH_ON] = ch_on_r;
        state_word[lcr_pkg::POS_UPDATE] = upd_r;
        state_word[lcr_pkg::POS_QHEAD] = qh_r;
        mask_word = WORD_ZERO;
        mask_word[lcr_pkg::IRQ_LSB +: N] = mask_r;
        flags_word = WORD_ZERO;
        flags_word[lcr_pkg::IRQ_LSB +: N] = flags_r;
    end

    // Selects are mutually exclusive, so gating and OR-ing is the mux
    wire [31:0] rd_mux = ({32{rsel_cfg1}} & cfg1_word)
                       | ({32{rsel_stride}} & stride_r)
                       | ({32{rsel_colour}} & colour_word)
                       | ({32{rsel_path}} & path_word)
                       | ({32{rsel_state}} & state_word)
                       | ({32{rsel_mask}} & mask_word)
                       | ({32{rsel_flags}} & flags_word);

    // Read data stand for one cycle only and are zero otherwise
    always_ff @(posedge CLK)
    begin
        if (RST)
            rdata_r <= WORD_ZERO;
        else if (RD)
            rdata_r <= rd_mux;
        else
            rdata_r <= WORD_ZERO;
    end
    assign RDATA = rdata_r;

endmodule // lcr_regs

`default_nettype wire

// ### core/lcr_pkg.sv
// Register map, field positions and encodings for the layer channel register bank.
// Assumes a byte-addressed plain register port; offsets below are byte addresses.
package lcr_pkg;
    localparam int ADDR_W = 32;
    localparam logic [31:0] OFF_BASE_CFG1 = 32'hF8038070;
    localparam logic [31:0] OFF_ROW_STRIDE = 32'hF8038074;
    localparam logic [31:0] OFF_DEF_COLOUR = 32'hF8038078;
    localparam logic [31:0] OFF_PATH_SEL = 32'hF803807C;
    localparam logic [31:0] OFF_CH_ENABLE = 32'hF8038100;
    localparam logic [31:0] OFF_CH_DISABLE = 32'hF8038104;
    localparam logic [31:0] OFF_CH_STATE = 32'hF8038108;
    localparam logic [31:0] OFF_IRQ_ENABLE = 32'hF803810C;
    localparam logic [31:0] OFF_IRQ_DISABLE = 32'hF8038110;
    localparam logic [31:0] OFF_IRQ_MASK = 32'hF8038114;
    localparam logic [31:0] OFF_IRQ_FLAGS = 32'hF8038118;
    // Base configuration 1 fields
    localparam int POS_PAL_ON = 0;
    localparam int POS_PAL_DEPTH = 8;
    // Default colour fields
    localparam int POS_RED = 16;
    localparam int POS_GREEN = 8;
    localparam int POS_BLUE = 0;
    // Path select fields
    localparam int POS_DMA_PATH = 8;
    localparam int POS_REPLICATE = 9;
    // Channel enable / state fields
    localparam int POS_CH_ON = 0;
    localparam int POS_UPDATE = 1;
    localparam int POS_QHEAD = 2;
    // Channel disable fields
    localparam int POS_GRACEFUL = 0;
    localparam int POS_ABORT = 8;
    // Interrupt source field: bits 6..2
    localparam int IRQ_LSB = 2;
    localparam int IRQ_N = 5;
    localparam int SRC_EOT = 0;
    localparam int SRC_DESCRIPTOR_LOADED = 1;
    localparam int SRC_HEAD = 2;
    localparam int SRC_EOL = 3;
    localparam int SRC_OVF = 4;
    localparam logic [31:0] RESET_WORD = 32'h00000000;
    // Palette depth codes
    localparam logic [1:0] PAL_1BPP = 2'h0;
    localparam logic [1:0] PAL_2BPP = 2'h1;
    localparam logic [1:0] PAL_4BPP = 2'h2;
    localparam logic [1:0] PAL_8BPP = 2'h3;
    localparam logic [3:0] BPP_1 = 4'h1;
    localparam logic [3:0] BPP_2 = 4'h2;
    localparam logic [3:0] BPP_4 = 4'h4;
    localparam logic [3:0] BPP_8 = 4'h8;
    localparam int COMP_W = 8;
endpackage

// ### test/lcr_regs_asserts.sv
// Concurrent checks on the layer channel register bank ports.
// Assumes the lcr_pkg register map; bound to every lcr_regs instance.
`timescale 1ns/1ps
`default_nettype none
module lcr_regs_asserts
(
    // Clock, reset and register port
    input wire logic CLK,
    input wire logic RST,
    input wire logic [31:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [31:0] RDATA,
    // Base layer
    input wire logic BASE_ROW_DONE,
    input wire logic [31:0] BASE_ROW_ADDR,
    input wire logic BASE_PAL_MODE,
    input wire logic [3:0] BASE_PAL_BPP,
    // Overlay-1 channel
    input wire logic OVL_EOF,
    input wire logic OVL_SOF,
    input wire logic OVL_HEAD_ADDED,
    input wire logic OVL_CHANNEL_ON,
    input wire logic OVL_ABORT,
    input wire logic OVL_APPLY_ATTR,
    input wire logic OVL_QUEUE_HEAD,
    // Events
    input wire logic EV_EOT,
    input wire logic EV_DESCRIPTOR_LOADED,
    input wire logic EV_HEAD,
    input wire logic EV_EOL,
    input wire logic EV_OVF
);
    logic [31:0] stride_r;
    wire logic [4:0] evs = {EV_OVF, EV_EOL, EV_HEAD, EV_DESCRIPTOR_LOADED, EV_EOT};
    wire logic flags_rd = RD && ADDR == lcr_pkg::OFF_IRQ_FLAGS;
    wire logic en_wr = WR && ADDR == lcr_pkg::OFF_CH_ENABLE;
    wire logic stride_wr = WR && ADDR == lcr_pkg::OFF_ROW_STRIDE;
    // Shadow stride so that a row step can be predicted
    always_ff @(posedge CLK)
        if (RST)
            stride_r <= '0;
        else if (stride_wr)
            stride_r <= WDATA;
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    chk_enable_on: assert property (en_wr && WDATA[0] |=> OVL_CHANNEL_ON)
        else $error("channel did not turn on");
    chk_abort_now: assert property (WR && ADDR == lcr_pkg::OFF_CH_DISABLE && WDATA[8]
        |=> OVL_ABORT && !OVL_CHANNEL_ON && !OVL_QUEUE_HEAD) else $error("abort missed");
    chk_apply_sof: assert property (OVL_APPLY_ATTR |-> OVL_SOF)
        else $error("attributes applied outside frame start");
    chk_graceful_eof: assert property ($fell(OVL_CHANNEL_ON) |-> OVL_ABORT || $past(OVL_EOF))
        else $error("channel dropped before frame end");
    chk_queue_set: assert property (en_wr && WDATA[2] |=> OVL_QUEUE_HEAD)
        else $error("queue request not pending");
    chk_queue_clear: assert property (OVL_QUEUE_HEAD && OVL_HEAD_ADDED && !(en_wr && WDATA[2])
        |=> !OVL_QUEUE_HEAD) else $error("queue request not cleared");
    chk_pal_off: assert property (!BASE_PAL_MODE |-> BASE_PAL_BPP == 4'h0)
        else $error("palette depth used outside palette mode");
    chk_row_step: assert property (BASE_ROW_DONE && !stride_wr
        |=> BASE_ROW_ADDR == $past(BASE_ROW_ADDR) + stride_r) else $error("row step wrong");
    chk_flags_clear: assert property (flags_rd && evs == 5'h0 ##1 evs == 5'h0
        ##1 flags_rd && evs == 5'h0 |=> RDATA[6:2] == 5'h0) else $error("flags not cleared");
    chk_flag_set: assert property (evs != 5'h0 ##2 flags_rd
        |=> (RDATA[6:2] & $past(evs, 3)) == $past(evs, 3)) else $error("event flag missing");
endmodule // lcr_regs_asserts
bind lcr_regs lcr_regs_asserts u_chk (.*);
`default_nettype wire

// ### test/lcr_regs_test.sv
// Self-checking bench for the layer channel register bank.
// Assumes lcr_pkg offsets; frame strobes and events are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module lcr_regs_test;
    logic CLK, RST, WR, RD;
    logic [31:0] ADDR, WDATA, RDATA, BASE_ROW_ADDR_START, BASE_ROW_ADDR;
    logic BASE_DMA_ON, BASE_PAL_MODE, OVL_CHANNEL_ON, OVL_ABORT, OVL_APPLY_ATTR;
    logic OVL_QUEUE_HEAD, OVL_IRQ;
    logic [3:0] BASE_PAL_BPP, PIX_COMP_BITS;
    logic [7:0] PIX_RED, PIX_GREEN, PIX_BLUE;
    logic [23:0] BASE_PIXEL;
    logic [8:0] pl;
    wire logic BASE_ROW_DONE, OVL_HEAD_ADDED, OVL_EOF, OVL_SOF;
    wire logic EV_OVF, EV_EOL, EV_HEAD, EV_DESCRIPTOR_LOADED, EV_EOT;
    int n_errors;
    int n_checks;
    assign {BASE_ROW_DONE, OVL_HEAD_ADDED, OVL_EOF, OVL_SOF} = pl[8:5];
    assign {EV_OVF, EV_EOL, EV_HEAD, EV_DESCRIPTOR_LOADED, EV_EOT} = pl[4:0];
    lcr_regs DUT (.*);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(posedge CLK);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge CLK);
        WR <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        @(posedge CLK);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge CLK);
        RD <= 1'b0;
        #1;
        chk(RDATA, e);
    endtask
    task automatic pulse(input logic [8:0] p);
        @(posedge CLK);
        pl <= p;
        @(posedge CLK);
        pl <= '0;
        #1;
    endtask
    task automatic print_verdict;
        if (n_errors == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        CLK = 1'b0;
        forever #20 CLK = ~CLK;
    end
    initial
    begin
        #100000;
        n_errors++;
        print_verdict;
    end
    initial
    begin
        {RST, WR, RD, ADDR, WDATA, pl} = {3'b100, 73'h0};
        {BASE_ROW_ADDR_START, PIX_RED, PIX_GREEN, PIX_BLUE} = 56'h10000000_13_0A_1F;
        PIX_COMP_BITS = 4'h5;
        n_errors = 0;
        n_checks = 0;
        repeat (3) @(posedge CLK);
        RST <= 1'b0;
        rd(lcr_pkg::OFF_CH_STATE, 32'h0);
        rd(32'hF8038200, 32'h0);
        rd(lcr_pkg::OFF_CH_ENABLE, 32'h0);
        for (int d = 0; d < 4; d++)
        begin
            wr(lcr_pkg::OFF_BASE_CFG1, 32'h1 | (d << 8));
            chk(BASE_PAL_BPP, 32'h1 << d);
            chk(BASE_PAL_MODE, 32'h1);
        end
        wr(lcr_pkg::OFF_BASE_CFG1, 32'h300);
        chk(BASE_PAL_BPP, 32'h0);
        chk(BASE_PAL_MODE, 32'h0);
        wr(lcr_pkg::OFF_ROW_STRIDE, 32'h140);
        chk(BASE_ROW_ADDR, 32'h10000000);
        wr(lcr_pkg::OFF_PATH_SEL, 32'h100);
        chk(BASE_DMA_ON, 32'h1);
        pulse(9'h100);
        pulse(9'h100);
        chk(BASE_ROW_ADDR, 32'h10000280);
        rd(lcr_pkg::OFF_ROW_STRIDE, 32'h140);
        chk(BASE_PIXEL, 24'h9850F8);
        wr(lcr_pkg::OFF_PATH_SEL, 32'h300);
        @(posedge CLK);
        #1;
        chk(BASE_PIXEL, 24'h9950F9);
        wr(lcr_pkg::OFF_DEF_COLOUR, 32'h00123456);
        wr(lcr_pkg::OFF_PATH_SEL, 32'h0);
        @(posedge CLK);
        #1;
        chk(BASE_PIXEL, 24'h123456);
        wr(lcr_pkg::OFF_CH_ENABLE, 32'h1);
        wr(lcr_pkg::OFF_CH_ENABLE, 32'h0);
        chk(OVL_CHANNEL_ON, 32'h1);
        wr(lcr_pkg::OFF_CH_ENABLE, 32'h6);
        rd(lcr_pkg::OFF_CH_STATE, 32'h7);
        chk(OVL_QUEUE_HEAD, 32'h1);
        @(posedge CLK);
        pl <= 9'h020;
        #1;
        chk(OVL_APPLY_ATTR, 32'h1);
        @(posedge CLK);
        pl <= '0;
        #1;
        rd(lcr_pkg::OFF_CH_STATE, 32'h5);
        pulse(9'h080);
        rd(lcr_pkg::OFF_CH_STATE, 32'h1);
        wr(lcr_pkg::OFF_CH_DISABLE, 32'h1);
        chk(OVL_CHANNEL_ON, 32'h1);
        pulse(9'h040);
        chk(OVL_CHANNEL_ON, 32'h0);
        wr(lcr_pkg::OFF_CH_ENABLE, 32'h7);
        wr(lcr_pkg::OFF_CH_DISABLE, 32'h100);
        chk(OVL_ABORT, 32'h1);
        rd(lcr_pkg::OFF_CH_STATE, 32'h0);
        wr(lcr_pkg::OFF_IRQ_ENABLE, 32'h7C);
        rd(lcr_pkg::OFF_IRQ_MASK, 32'h7C);
        wr(lcr_pkg::OFF_IRQ_DISABLE, 32'h14);
        wr(lcr_pkg::OFF_IRQ_ENABLE, 32'h0);
        rd(lcr_pkg::OFF_IRQ_MASK, 32'h68);
        for (int i = 0; i < 5; i++)
        begin
            pulse(9'h1 << i);
            chk(OVL_IRQ, (32'h68 >> (i + 2)) & 32'h1);
            rd(lcr_pkg::OFF_IRQ_FLAGS, 32'h4 << i);
            rd(lcr_pkg::OFF_IRQ_FLAGS, 32'h0);
        end
        @(posedge CLK);
        RST <= 1'b1;
        repeat (3) @(posedge CLK);
        RST <= 1'b0;
        rd(lcr_pkg::OFF_IRQ_MASK, 32'h0);
        print_verdict;
    end
endmodule // lcr_regs_test
`default_nettype wire
